// *** logic/lpd_params.svh ***
// Purpose: Shared constants for the LED PWM engine and its serial-bus controller.
// Assumes: Included by bare name; the guard allows repeated inclusion.
// Notes:   Offsets are register indices on the serial link and byte addresses on Avalon-MM.
`ifndef LPD_PARAMS_SVH
`define LPD_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define LPD_MCLK_HZ        20000000
`define LPD_PWM_HZ         97000
`define LPD_DIM_HZ         190
`define LPD_BLINK_MAX_HZ   24
`define LPD_PWM_STEPS      256
`define LPD_HOST_QTR_CYC   5

// ****************************************************************
// Device register indices and reset values
// ****************************************************************
`define LPD_REG_MODE1      4'h0
`define LPD_REG_MODE2      4'h1
`define LPD_REG_DUTY0      4'h2
`define LPD_REG_GROUP_DUTY 4'h6
`define LPD_REG_GROUP_FREQ 4'h7
`define LPD_REG_LED_SEL    4'h8
`define LPD_REG_LAST       4'h8
`define LPD_RST_MODE1      8'h00
`define LPD_RST_MODE2      8'h04
`define LPD_RST_DUTY       8'h00
`define LPD_RST_GROUP_DUTY 8'hFF
`define LPD_RST_GROUP_FREQ 8'h00
`define LPD_RST_LED_SEL    8'h00

// ****************************************************************
// Device field positions
// ****************************************************************
`define LPD_MODE1_HALT     4
`define LPD_MODE2_BLINK    5
`define LPD_MODE2_INVERT   4
`define LPD_MODE2_OUTDRV   2
`define LPD_MODE2_DISOUT   0

// ****************************************************************
// Controller registers on Avalon-MM
// ****************************************************************
`define LPD_AV_CMD         4'h0
`define LPD_AV_STATUS      4'h4
`define LPD_CMD_START      8
`define LPD_CMD_STOP       9
`define LPD_CMD_READ       10
`define LPD_CMD_NACK       11
`define LPD_STAT_BUSY      0
`define LPD_STAT_NACKED    1
`define LPD_STAT_RX        8

`endif

// *** logic/lpd_pkg.sv ***
// Purpose: Types shared by both ends of the LED PWM serial link.
// Assumes: Nothing beyond the constants header.
// Notes:   State encodings follow a Gray sequence along the usual path, except the device's ADDR-to-READ step.
package lpd_pkg;
    typedef logic [7:0] lpd_byte_t;
    typedef enum logic [1:0] {
        LPD_D_IDLE  = 2'b00,
        LPD_D_ADDR  = 2'b01,
        LPD_D_WRITE = 2'b11,
        LPD_D_READ  = 2'b10
    } lpd_dev_state_e;
    typedef enum logic [1:0] {
        LPD_H_IDLE  = 2'b00,
        LPD_H_START = 2'b01,
        LPD_H_BIT   = 2'b11,
        LPD_H_STOP  = 2'b10
    } lpd_host_state_e;
endpackage

// *** logic/lpd_i2c_if.sv ***
// Purpose: Two-wire open-drain link between the bus controller and the LED device.
// Assumes: Both lines are pulled high when nobody drives them low.
// Notes:   An enable that is high means that party drives its output value.
`timescale 1ns/1ps
interface lpd_i2c_if;
    logic scl_out_m;
    logic scl_oe_m;
    logic sda_out_m;
    logic sda_oe_m;
    logic sda_out_d;
    logic sda_oe_d;
    logic scl;
    logic sda;

    assign scl = (scl_oe_m && !scl_out_m) ? 1'b0 : 1'b1;
    assign sda = ((sda_oe_m && !sda_out_m) || (sda_oe_d && !sda_out_d)) ? 1'b0 : 1'b1;

    modport master (output scl_out_m, output scl_oe_m, output sda_out_m, output sda_oe_m,
                    input scl, input sda);
    modport device (output sda_out_d, output sda_oe_d, input scl, input sda);
endinterface

// *** logic/lpd_host.sv ***
// Purpose: Serial-bus master that software drives byte by byte over Avalon-MM.
// Assumes: One byte operation at a time; the device never stretches the clock.
// Notes:   Writes to the command register stall on waitrequest while a byte is in flight.
`timescale 1ns/1ps
`include "lpd_params.svh"
module lpd_host
    import lpd_pkg::*;
#(
    parameter int QTR_CYC = `LPD_HOST_QTR_CYC
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    lpd_i2c_if.master        bus
);
    generate
        if (QTR_CYC < 4 || QTR_CYC > 255) begin : g_bad
            $error("QTR_CYC must lie in 4..255");
        end
    endgenerate

    logic            scl_s1, scl_s2, sda_s1, sda_s2;
    lpd_host_state_e st;
    logic [1:0]      step;
    logic [3:0]      bitn;
    logic [7:0]      qdiv;
    lpd_byte_t       tx, rx;
    logic            do_stop, do_read, nack_out, busy, nacked;
    logic            accept, go, qtick;

    assign bus.scl_out_m = 1'b0;
    assign bus.sda_out_m = 1'b0;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            scl_s1 <= bus.scl;
            scl_s2 <= scl_s1;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
        end
    end

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    assign accept = (avs_read || avs_write) && avs_waitrequest &&
                    !(avs_write && avs_address == `LPD_AV_CMD && busy);
    assign go     = accept && avs_write && avs_address == `LPD_AV_CMD;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !accept;
            if (accept && avs_read) begin
                avs_readdata <= 32'h0000_0000;
                if (avs_address == `LPD_AV_STATUS) begin
                    avs_readdata[`LPD_STAT_BUSY]        <= busy;
                    avs_readdata[`LPD_STAT_NACKED]      <= nacked;
                    avs_readdata[`LPD_STAT_RX +: 8]     <= rx;
                end
            end
        end
    end

    // ****************************************************************
    // Bit engine
    // ****************************************************************
    assign qtick = (qdiv == 8'(QTR_CYC - 1));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            qdiv <= 8'h00;
        end else if (st == LPD_H_IDLE || qtick) begin
            qdiv <= 8'h00;
        end else begin
            qdiv <= qdiv + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st       <= LPD_H_IDLE;
            step     <= 2'd0;
            bitn     <= 4'd0;
            tx       <= 8'h00;
            rx       <= 8'h00;
            do_stop  <= 1'b0;
            do_read  <= 1'b0;
            nack_out <= 1'b0;
            busy     <= 1'b0;
            nacked   <= 1'b0;
            bus.scl_oe_m <= 1'b0;
            bus.sda_oe_m <= 1'b0;
        end else if (st == LPD_H_IDLE) begin
            if (go) begin
                tx       <= avs_writedata[7:0];
                do_stop  <= avs_writedata[`LPD_CMD_STOP];
                do_read  <= avs_writedata[`LPD_CMD_READ];
                nack_out <= avs_writedata[`LPD_CMD_NACK];
                busy     <= 1'b1;
                step     <= 2'd0;
                bitn     <= 4'd0;
                st       <= avs_writedata[`LPD_CMD_START] ? LPD_H_START : LPD_H_BIT;
            end
        end else if (qtick) begin
            step <= step + 2'd1;
            case (st)
                LPD_H_START: begin
                    case (step)
                        2'd0: bus.sda_oe_m <= 1'b0;
                        2'd1: bus.scl_oe_m <= 1'b0;
                        2'd2: begin
                            if (sda_s2 && scl_s2) begin
                                bus.sda_oe_m <= 1'b1;
                            end else begin
                                step <= 2'd2;
                            end
                        end
                        default: begin
                            bus.scl_oe_m <= 1'b1;
                            st           <= LPD_H_BIT;
                        end
                    endcase
                end
                LPD_H_BIT: begin
                    case (step)
                        2'd0: begin
                            if (bitn == 4'd8) begin
                                bus.sda_oe_m <= do_read && !nack_out;
                            end else begin
                                bus.sda_oe_m <= !do_read && !tx[7];
                            end
                        end
                        2'd1: bus.scl_oe_m <= 1'b0;
                        2'd2: begin
                            if (bitn == 4'd8) begin
                                nacked <= sda_s2;
                            end else begin
                                rx <= {rx[6:0], sda_s2};
                                tx <= {tx[6:0], 1'b0};
                            end
                        end
                        default: begin
                            bus.scl_oe_m <= 1'b1;
                            bitn         <= bitn + 4'd1;
                            if (bitn == 4'd8) begin
                                bus.sda_oe_m <= 1'b0;
                                st           <= do_stop ? LPD_H_STOP : LPD_H_IDLE;
                                busy         <= do_stop;
                            end
                        end
                    endcase
                end
                LPD_H_STOP: begin
                    case (step)
                        2'd0: bus.sda_oe_m <= 1'b1;
                        2'd1: bus.scl_oe_m <= 1'b0;
                        2'd2: bus.sda_oe_m <= 1'b0;
                        default: begin
                            st   <= LPD_H_IDLE;
                            busy <= 1'b0;
                        end
                    endcase
                end
                default: st <= LPD_H_IDLE;
            endcase
        end
    end
endmodule

// *** logic/lpd_device.sv ***
// Purpose: Four-channel LED PWM engine with group dimming or blinking, set up over
//          a two-wire serial slave.
// Assumes: mclk stands in for the internal oscillator; the bus lines are asynchronous.
// Notes:   After the address byte a write's first byte selects a register index,
//          later bytes store and advance it; reads return from the index onward.
// Notes on behaviour
// - Per-channel 8-bit duty PWM near 97 kHz; the code runs it at mclk/256, 78.125 kHz.
// - Group dimming at about 190 Hz, 8-bit duty.
// - Blink period in 256 steps, 24 Hz down.
// - One group signal overlays all channel PWM.
// - One bit per clock; data steady high.
// - Data falling while clock high starts transfer.
// - Data rising while clock high ends transfer.
// - Master starts only when both lines high.
// - Each byte followed by one acknowledge slot.
// - Master clocks the acknowledge slot.
// - Device acknowledges every byte it receives.
// - Master acknowledges read bytes except last.
// - Acknowledger holds data low during clock high.
// - Master ends read with a missing acknowledge.
// - Device releases data after final unacknowledged byte.
// - Halt bit freezes oscillator and all outputs.
// - Outputs power up push-pull, driven high.
// - Polarity inversion only while enable is low.
// - Enable high: disabled-state field sets outputs.
`timescale 1ns/1ps
`include "lpd_params.svh"
module lpd_device
    import lpd_pkg::*;
#(
    parameter int        CHANNELS = 4,
    parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary default address.
) (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    lpd_i2c_if.device                bus,
    input  wire logic                output_enable_n,
    output logic      [CHANNELS-1:0] led_out,
    output logic      [CHANNELS-1:0] led_oe
);
    localparam int PWM_RAW   = `LPD_MCLK_HZ / (`LPD_PWM_HZ * `LPD_PWM_STEPS);
    localparam int PWM_DIV   = (PWM_RAW < 1) ? 1 : PWM_RAW;
    localparam int DIM_DIV   = `LPD_MCLK_HZ / (`LPD_DIM_HZ * `LPD_PWM_STEPS);
    localparam int BLINK_DIV = `LPD_MCLK_HZ / (`LPD_BLINK_MAX_HZ * `LPD_PWM_STEPS);

    generate
        if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad
            $error("CHANNELS must lie in 1..4");
        end
    endgenerate

    // ****************************************************************
    // Line synchronisers and condition detection
    // ****************************************************************
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, oe_n_s1, oe_n_s2;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'b111;
            {sda_s1, sda_s2, sda_s3} <= 3'b111;
            {oe_n_s1, oe_n_s2}       <= 2'b00;
        end else begin
            scl_s1  <= bus.scl;
            scl_s2  <= scl_s1;
            scl_s3  <= scl_s2;
            sda_s1  <= bus.sda;
            sda_s2  <= sda_s1;
            sda_s3  <= sda_s2;
            oe_n_s1 <= output_enable_n;
            oe_n_s2 <= oe_n_s1;
        end
    end

    assign scl_rise   = scl_s2 && !scl_s3;
    assign scl_fall   = !scl_s2 && scl_s3;
    assign start_seen = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign stop_seen  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

    // ****************************************************************
    // Register file
    // ****************************************************************
    lpd_byte_t regs [0:`LPD_REG_LAST];
    lpd_dev_state_e st;
    logic [3:0]     bitcnt;
    logic [3:0]     ptr;
    lpd_byte_t      shreg, txsh, rd_val;
    logic           ackph, rw, first, wr_en, byte_end;

    assign byte_end = scl_fall && !ackph && bitcnt == 4'd8 && !start_seen && !stop_seen;
    assign wr_en    = byte_end && st == LPD_D_WRITE && !first;
    assign rd_val   = (ptr <= `LPD_REG_LAST) ? regs[ptr] : 8'h00;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            regs[`LPD_REG_MODE1]      <= `LPD_RST_MODE1;
            regs[`LPD_REG_MODE2]      <= `LPD_RST_MODE2;
            for (int i = 0; i < 4; i++) begin
                regs[`LPD_REG_DUTY0 + 4'(i)] <= `LPD_RST_DUTY;
            end
            regs[`LPD_REG_GROUP_DUTY] <= `LPD_RST_GROUP_DUTY;
            regs[`LPD_REG_GROUP_FREQ] <= `LPD_RST_GROUP_FREQ;
            regs[`LPD_REG_LED_SEL]    <= `LPD_RST_LED_SEL;
        end else if (wr_en && ptr <= `LPD_REG_LAST) begin
            regs[ptr] <= shreg;
        end
    end

    // ****************************************************************
    // Serial slave
    // ****************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st           <= LPD_D_IDLE;
            bitcnt       <= 4'd0;
            shreg        <= 8'h00;
            txsh         <= 8'h00;
            ackph        <= 1'b0;
            rw           <= 1'b0;
            first        <= 1'b0;
            ptr          <= 4'd0;
            bus.sda_oe_d <= 1'b0;
        end else if (start_seen) begin
            st           <= LPD_D_ADDR;
            bitcnt       <= 4'd0;
            ackph        <= 1'b0;
            bus.sda_oe_d <= 1'b0;
        end else if (stop_seen) begin
            st           <= LPD_D_IDLE;
            ackph        <= 1'b0;
            bus.sda_oe_d <= 1'b0;
        end else if (st != LPD_D_IDLE) begin
            if (scl_rise) begin
                if (!ackph) begin
                    shreg  <= {shreg[6:0], sda_s2};
                    txsh   <= {txsh[6:0], 1'b0};
                    bitcnt <= bitcnt + 4'd1;
                end else if (st == LPD_D_READ && sda_s2) begin
                    st <= LPD_D_IDLE;
                end
            end
            if (byte_end) begin
                ackph <= 1'b1;
                case (st)
                    LPD_D_ADDR: begin
                        if (shreg[7:1] == DEV_ADDR) begin
                            bus.sda_oe_d <= 1'b1;
                            rw           <= shreg[0];
                        end else begin
                            st <= LPD_D_IDLE;
                        end
                    end
                    LPD_D_WRITE: begin
                        bus.sda_oe_d <= 1'b1;
                        if (first) begin
                            ptr <= shreg[3:0];
                        end else begin
                            ptr <= (ptr >= `LPD_REG_LAST) ? 4'd0 : ptr + 4'd1;
                        end
                        first <= 1'b0;
                    end
                    default: bus.sda_oe_d <= 1'b0;
                endcase
            end else if (scl_fall && ackph) begin
                ackph        <= 1'b0;
                bitcnt       <= 4'd0;
                bus.sda_oe_d <= 1'b0;
                if ((st == LPD_D_ADDR && rw) || st == LPD_D_READ) begin
                    st           <= LPD_D_READ;
                    txsh         <= rd_val;
                    bus.sda_oe_d <= !rd_val[7];
                    ptr          <= (ptr >= `LPD_REG_LAST) ? 4'd0 : ptr + 4'd1;
                end else if (st == LPD_D_ADDR) begin
                    st    <= LPD_D_WRITE;
                    first <= 1'b1;
                end
            end else if (scl_fall && st == LPD_D_READ) begin
                bus.sda_oe_d <= !txsh[7];
            end
        end else begin
            bus.sda_oe_d <= 1'b0;
        end
    end

    assign bus.sda_out_d = 1'b0;

    // ****************************************************************
    // Oscillator-driven counters
    // ****************************************************************
    // The halt bit freezes every counter, so outputs hold their level instead of
    // collapsing to one state; that matches a stopped oscillator.
    logic       run, blink, grp_step, pwm_step;
    logic [7:0] pwm_div_cnt, pwm_cnt, grp_mul, grp_cnt;
    logic [11:0] grp_pre;

    assign run      = !regs[`LPD_REG_MODE1][`LPD_MODE1_HALT];
    assign blink    = regs[`LPD_REG_MODE2][`LPD_MODE2_BLINK];
    assign pwm_step = run && pwm_div_cnt == 8'(PWM_DIV - 1);
    assign grp_step = run && grp_pre == 12'(blink ? BLINK_DIV - 1 : DIM_DIV - 1);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_div_cnt <= 8'h00;
            pwm_cnt     <= 8'h00;
        end else if (run) begin
            pwm_div_cnt <= pwm_step ? 8'h00 : pwm_div_cnt + 8'h01;
            if (pwm_step) begin
                pwm_cnt <= pwm_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            grp_pre <= 12'h000;
            grp_mul <= 8'h00;
            grp_cnt <= 8'h00;
        end else if (run) begin
            grp_pre <= grp_step ? 12'h000 : grp_pre + 12'h001;
            if (grp_step) begin
                if (!blink || grp_mul >= regs[`LPD_REG_GROUP_FREQ]) begin
                    grp_mul <= 8'h00;
                    grp_cnt <= grp_cnt + 8'h01;
                end else begin
                    grp_mul <= grp_mul + 8'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    logic grp_on, invert, outdrv;
    logic [1:0] disout;

    assign grp_on = grp_cnt < regs[`LPD_REG_GROUP_DUTY];
    assign invert = regs[`LPD_REG_MODE2][`LPD_MODE2_INVERT];
    assign outdrv = regs[`LPD_REG_MODE2][`LPD_MODE2_OUTDRV];
    assign disout = regs[`LPD_REG_MODE2][`LPD_MODE2_DISOUT +: 2];

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            logic [1:0] sel;
            logic       ch_on, lit, lvl;
            assign sel   = regs[`LPD_REG_LED_SEL][2*g +: 2];
            assign ch_on = pwm_cnt < regs[`LPD_REG_DUTY0 + 4'(g)];
            assign lit   = (sel == 2'b01) || (sel == 2'b10 && ch_on) ||
                           (sel == 2'b11 && ch_on && grp_on);
            assign lvl   = !lit ^ invert;

            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    led_out[g] <= 1'b1;
                    led_oe[g]  <= 1'b1;
                end else if (run) begin
                    if (oe_n_s2) begin
                        led_out[g] <= disout[0];
                        led_oe[g]  <= !disout[1] && (outdrv || !disout[0]);
                    end else begin
                        led_out[g] <= lvl;
                        led_oe[g]  <= outdrv || !lvl;
                    end
                end
            end
        end
    endgenerate
endmodule

// *** testbench/lpd_sva.sv ***
// Purpose: Bus checks on the two-wire link between host and LED device.
// Assumes: Lines sampled on mclk; sys_rst async, active high.
// Notes:   The bit counter restarts at every start condition.
`timescale 1ns/1ps
module lpd_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_oe_d,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q, sda_q, first, rw;
    logic [3:0] cnt;
    wire        start_c = scl && scl_q && sda_q && !sda;
    wire        stop_c  = scl && scl_q && !sda_q && sda;
    wire        rise    = scl && !scl_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_q, sda_q} <= 2'h3;
        end else begin
            {scl_q, sda_q} <= {scl, sda};
        end
    end
    // Slot 8 of each byte is the acknowledge; the first byte carries the direction.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {cnt, first, rw} <= 6'h00;
        end else if (start_c) begin
            {cnt, first} <= 5'h01;
        end else if (rise) begin
            cnt   <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            first <= first && (cnt != 4'h8);
            rw    <= (first && cnt == 4'h7) ? sda : rw;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence ack_rise;
        rise && cnt == 4'h8 && !sda;
    endsequence
    sequence nack_rise;
        rise && cnt == 4'h8 && rw && !first && sda;
    endsequence
    AST_HOLD_HIGH: assert property (scl && scl_q |-> sda_oe_d == $past(sda_oe_d))
        else $error("data moved in clock high");
    AST_WR_ACK: assert property (rise && cnt == 4'h8 && (first || !rw) |-> !sda)
        else $error("byte not acked");
    AST_ACK_STEADY: assert property (ack_rise |=> !sda [*3])
        else $error("ack not steady");
    AST_NACK_REL: assert property (nack_rise |-> ##12 !sda_oe_d [*8])
        else $error("data held after nack");
    AST_START_FREE: assert property (start_c |-> $past(scl_q) && $past(sda_q))
        else $error("start on busy bus");
    AST_START_SCL: assert property (start_c |-> ##[1:8] !scl)
        else $error("clock not pulled after start");
    AST_STOP_IDLE: assert property (stop_c |=> (scl && sda) [*6])
        else $error("bus not free after stop");
    AST_RST_IDLE: assert property ($fell(sys_rst) |-> scl && sda && !sda_oe_d)
        else $error("bus not idle after reset");
endmodule

// *** testbench/lpd_tb.sv ***
// Purpose: Drives the host over Avalon-MM and checks the LED device end to end.
// Assumes: Device answers at its default address 7'h2A.
// Notes:   LED waits after selection changes span two PWM periods so outputs settle; mode changes wait 10 cycles.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("FAIL %0t mismatch", $time); end end
module led_pwm_dim_blink_i2c_slave_tb_top;
    logic        mclk = 1'b0, sys_rst = 1'b1, output_enable_n = 1'b0, nk;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0]  avs_address = 4'h0, led_out, led_oe;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rdat;
    logic [7:0]  lsel, b, exp_q[$];
    logic [8:0]  on_cnt [4];
    int          error_cnt = 0, total_checks = 0;
    lpd_i2c_if bus ();
    lpd_host lpd_host_inst (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(bus.master));
    lpd_device lpd_device_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(bus.device),
        .output_enable_n(output_enable_n), .led_out(led_out), .led_oe(led_oe));
    lpd_sva lpd_sva_inst (.mclk(mclk), .sys_rst(sys_rst), .scl_oe_m(bus.scl_oe_m),
        .sda_oe_m(bus.sda_oe_m), .sda_oe_d(bus.sda_oe_d), .scl(bus.scl), .sda(bus.sda));
    initial begin
        forever #25 mclk = ~mclk;
    end
    function automatic logic [3:0] exp_led(input logic [7:0] s);
        for (int i = 0; i < 4; i++) exp_led[i] = !s[2*i];
    endfunction
    task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
    endtask
    // Polling is bounded so a stuck busy flag ends as a mismatch, not a hang.
    task automatic xfer(input logic [11:0] c);
        int n;
        av(4'h0, 1'b1, {20'h0_0000, c});
        n = 0;
        do begin av(4'h4, 1'b0, 32'h0000_0000); n++; end while (rdat[0] !== 1'b0 && n < 300);
        `CHK(rdat[0], 1'b0)
        {b, nk} = {rdat[15:8], rdat[1]};
    endtask
    task automatic wr_reg(input logic [3:0] idx, input logic [7:0] v);
        xfer(12'h154);
        xfer({8'h00, idx});
        xfer({4'h2, v});
        `CHK(nk, 1'b0)
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h297083bb));
        repeat (10) @(posedge mclk);
        `CHK({led_out, led_oe}, 8'hFF)
        sys_rst <= 1'b0;
        av(4'hC, 1'b0, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0000)
        xfer(12'h154);
        xfer(12'h002);
        for (int i = 0; i < 7; i++) begin
            exp_q.push_back((i == 6) ? 8'($urandom) & 8'h55 : 8'($urandom));
            xfer({(i == 6) ? 4'h2 : 4'h0, exp_q[i]});
            `CHK(nk, 1'b0)
        end
        lsel = exp_q[6];
        repeat (600) @(posedge mclk);
        `CHK(led_out, exp_led(lsel))
        xfer(12'h154);
        xfer(12'h002);
        xfer(12'h155);
        for (int i = 0; i < 7; i++) begin
            xfer((i == 6) ? 12'hE00 : 12'h400);
            `CHK({b, nk}, {exp_q[i], i == 6})
        end
        wr_reg(4'h0, 8'h10);
        wr_reg(4'h8, lsel ^ 8'h55);
        repeat (600) @(posedge mclk);
        `CHK(led_out, exp_led(lsel))
        wr_reg(4'h0, 8'h00);
        repeat (600) @(posedge mclk);
        `CHK(led_out, exp_led(lsel ^ 8'h55))
        wr_reg(4'h1, 8'h14);
        repeat (10) @(posedge mclk);
        `CHK(led_out, ~exp_led(lsel ^ 8'h55))
        wr_reg(4'h8, 8'hAA);
        on_cnt = '{default: 9'h000};
        repeat (256) begin
            @(posedge mclk);
            foreach (on_cnt[i]) on_cnt[i] += {8'h00, led_out[i]};
        end
        foreach (on_cnt[i]) `CHK(on_cnt[i], {1'b0, exp_q[i]})
        output_enable_n <= 1'b1;
        repeat (10) @(posedge mclk);
        `CHK(led_out, 4'h0)
        `CHK(led_oe, 4'hF)
        give_verdict;
    end
    initial begin
        #3_000_000;
        error_cnt++;
        give_verdict;
    end
endmodule
